// ==== wsw_pkg.sv ====
package wsw_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SVC_MIN_NS = 100000;
  localparam int SVC_MIN_CYC = (SVC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_PERIOD_US = 10000;
  localparam int WD_PERIOD_CYC = WD_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int INIT_SHIFT = 3;
  localparam int RATIO_DIV = 9;
  localparam int HOLD_DIV = 5;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] REG_PERIOD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_FAULTS = 4'h8;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_PINS_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    WSW_OFF,
    WSW_INIT,
    WSW_OPEN,
    WSW_CLOSED,
    WSW_FAULT
  } wsw_state_t;

endpackage : wsw_pkg

// ==== wsw_sync.sv ====
`timescale 1ns/10ps
module wsw_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } wsw_sync_t;

  wsw_sync_t r;
  wsw_sync_t next_r;

  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule : wsw_sync

// ==== wsw_axil.sv ====
`timescale 1ns/10ps
module wsw_axil #(
  parameter int ADDR_W = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data
);
  typedef struct packed {
    logic aw_v;
    logic [ADDR_W-1:0] awaddr;
    logic w_v;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
  } wsw_axil_t;

  wsw_axil_t r;
  wsw_axil_t next_r;

  assign s_axi_awready = !r.aw_v && !r.bvalid;
  assign s_axi_wready = !r.w_v && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign wr_en = r.aw_v && r.w_v && !r.bvalid;
  assign wr_addr = r.awaddr;
  assign wr_data = r.wdata;
  assign wr_strb = r.wstrb;
  assign rd_addr = s_axi_araddr;

  always_comb begin
    next_r = r;
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_v = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_v = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (wr_en) begin
      next_r.aw_v = 1'b0;
      next_r.w_v = 1'b0;
      next_r.bvalid = 1'b1;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_data;
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = wsw_pkg::RESP_OKAY;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = wsw_pkg::RESP_OKAY;
endmodule : wsw_axil

// ==== wsw_top.sv ====
// Summary of operation
// - power good high: enable pin low enables
// - power good low: disabled, fault output released
// - power good rising while enabled starts initialization
// - enable falling with power good starts initialization
// - fault pulse end restarts initialization
// - type select low selects window mode
// - type select high selects standard mode
// - initialization window lasts eight periods
// - window mode: open service starts closed window
// - service in closed window gives one fault
// - window mode: unserviced open window faults
// - unserviced initialization window faults
// - standard mode: service restarts open window
// - standard mode: no service in period faults
// - correct servicing keeps fault output released
// - fault drives output low twenty percent period
// - ratio select: equal split or 8:1
`timescale 1ns/10ps
module wsw_top #(
  parameter int ADDR_W = 4,
  parameter int PERIOD_W = 28,
  parameter int WD_PERIOD_CYC = wsw_pkg::WD_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic power_good,
  input wire logic watchdog_enable_n,
  input wire logic watchdog_service,
  input wire logic watchdog_type_select,
  input wire logic window_ratio_select,
  output logic watchdog_fault_out,
  output logic watchdog_fault_oe,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int CNT_W = PERIOD_W + wsw_pkg::INIT_SHIFT;
  localparam int SVC_W = $clog2(wsw_pkg::SVC_MIN_CYC + 1);
  localparam logic [SVC_W-1:0] SVC_LAST = SVC_W'(wsw_pkg::SVC_MIN_CYC - 1);

  typedef struct packed {
    wsw_pkg::wsw_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [PERIOD_W-1:0] period;
    logic [SVC_W-1:0] svc_cnt;
    logic [15:0] faults;
    logic fault_oe;
  } wsw_top_t;

  localparam wsw_top_t RST_VAL = '{
    st: wsw_pkg::WSW_OFF,
    cnt: '0,
    period: PERIOD_W'(WD_PERIOD_CYC),
    svc_cnt: '0,
    faults: '0,
    fault_oe: 1'b0
  };

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  logic rst_n;
  logic [4:0] pins_s;
  logic pg_s;
  logic wden_s;
  logic svc_s;
  logic type_s;
  logic ratio_s;

  wsw_sync #(.W(1)) u_rst (
    .core_clk(core_clk),
    .rst_n(nrst),
    .d(1'b1),
    .q(rst_n)
  );

  wsw_sync #(.W(5)) u_pins (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d({window_ratio_select, watchdog_type_select, watchdog_service, watchdog_enable_n, power_good}),
    .q(pins_s)
  );

  assign pg_s = pins_s[0];
  assign wden_s = pins_s[1];
  assign svc_s = pins_s[2];
  assign type_s = pins_s[3];
  assign ratio_s = pins_s[4];

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;

  wsw_axil #(.ADDR_W(ADDR_W)) u_axil (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ------------------------------------------------------------
  // window lengths
  // ------------------------------------------------------------
  wsw_top_t r;
  wsw_top_t next_r;
  logic en;
  logic svc_evt;
  logic [CNT_W-1:0] init_len;
  logic [CNT_W-1:0] open_len;
  logic [CNT_W-1:0] closed_len;
  logic [CNT_W-1:0] hold_len;
  logic [CNT_W-1:0] per;
  logic [CNT_W-1:0] ninth;

  assign en = pg_s && !wden_s;
  assign per = CNT_W'(r.period);
  assign ninth = per / CNT_W'(wsw_pkg::RATIO_DIV);
  assign init_len = per << wsw_pkg::INIT_SHIFT;
  assign hold_len = per / CNT_W'(wsw_pkg::HOLD_DIV);

  always_comb begin
    if (type_s) begin
      open_len = per;
      closed_len = '0;
    end else if (ratio_s) begin
      open_len = per - ninth;
      closed_len = ninth;
    end else begin
      open_len = per >> 1;
      closed_len = per - (per >> 1);
    end
  end

  // service counts once, after staying high for the minimum time
  assign svc_evt = svc_s && (r.svc_cnt == SVC_LAST);

  // ------------------------------------------------------------
  // watchdog sequencer
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] pw;
    logic fault_now;
    pw = 32'(r.period);
    fault_now = 1'b0;
    next_r = r;
    if (!svc_s) begin
      next_r.svc_cnt = '0;
    end else if (r.svc_cnt != SVC_W'(wsw_pkg::SVC_MIN_CYC)) begin
      next_r.svc_cnt = r.svc_cnt + 1'b1;
    end
    next_r.cnt = r.cnt + 1'b1;
    if (!en) begin
      next_r.st = wsw_pkg::WSW_OFF;
      next_r.cnt = '0;
    end else begin
      case (r.st)
        wsw_pkg::WSW_OFF: begin
          next_r.st = wsw_pkg::WSW_INIT;
          next_r.cnt = '0;
        end
        wsw_pkg::WSW_INIT, wsw_pkg::WSW_OPEN: begin
          if (svc_evt) begin
            next_r.st = type_s ? wsw_pkg::WSW_OPEN : wsw_pkg::WSW_CLOSED;
            next_r.cnt = '0;
          end else if (r.cnt >= ((r.st == wsw_pkg::WSW_INIT) ? init_len : open_len) - 1'b1) begin
            fault_now = 1'b1;
          end
        end
        wsw_pkg::WSW_CLOSED: begin
          if (svc_evt) begin
            fault_now = 1'b1;
          end else if (r.cnt >= closed_len - 1'b1) begin
            next_r.st = wsw_pkg::WSW_OPEN;
            next_r.cnt = '0;
          end
        end
        wsw_pkg::WSW_FAULT: begin
          if (r.cnt >= hold_len - 1'b1) begin
            next_r.st = wsw_pkg::WSW_INIT;
            next_r.cnt = '0;
          end
        end
        default: begin
          next_r.st = wsw_pkg::WSW_OFF;
          next_r.cnt = '0;
        end
      endcase
    end
    if (fault_now) begin
      next_r.st = wsw_pkg::WSW_FAULT;
      next_r.cnt = '0;
    end
    // open drain: driven low only while in fault
    next_r.fault_oe = (next_r.st == wsw_pkg::WSW_FAULT);
    for (int b = 0; b < 4; b++) begin
      if (wr_en && wr_addr == wsw_pkg::REG_PERIOD && wr_strb[b]) begin
        pw[b*8 +: 8] = wr_data[b*8 +: 8];
      end
    end
    next_r.period = pw[PERIOD_W-1:0];
    if (wr_en && wr_addr == wsw_pkg::REG_FAULTS) begin
      next_r.faults = '0;
    end
    if (fault_now && r.faults != 16'hffff) begin
      next_r.faults = r.faults + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= RST_VAL;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    rd_data = '0;
    case (rd_addr)
      wsw_pkg::REG_PERIOD: rd_data = 32'(r.period);
      wsw_pkg::REG_STATUS: begin
        rd_data[wsw_pkg::STAT_STATE_LSB +: 3] = r.st;
        rd_data[wsw_pkg::STAT_FAULT_BIT] = r.fault_oe;
        rd_data[wsw_pkg::STAT_PINS_LSB +: 5] = pins_s;
      end
      wsw_pkg::REG_FAULTS: rd_data = 32'(r.faults);
      default: rd_data = '0;
    endcase
  end

  assign watchdog_fault_out = 1'b0;
  assign watchdog_fault_oe = r.fault_oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_pg_low_release: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pg_s |=> !watchdog_fault_oe && r.st == wsw_pkg::WSW_OFF) else $error("fault out held with power low");
  a_disable_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pg_s && wden_s) |=> r.st == wsw_pkg::WSW_OFF) else $error("watchdog not disabled");
  a_start_init: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r.st == wsw_pkg::WSW_OFF && en) |=> r.st == wsw_pkg::WSW_INIT && r.cnt == '0) else $error("no init start");
  a_fault_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r.st == wsw_pkg::WSW_FAULT && en && r.cnt == hold_len - 1'b1) |=> r.st == wsw_pkg::WSW_INIT && !watchdog_fault_oe)
    else $error("no restart after fault");
  a_closed_service: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r.st == wsw_pkg::WSW_CLOSED && en && svc_evt) |=> watchdog_fault_oe ##1 !svc_evt [*1])
    else $error("closed window service missed");
  a_win_service: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r.st inside {wsw_pkg::WSW_INIT, wsw_pkg::WSW_OPEN} && en && svc_evt && !type_s) |=> r.st == wsw_pkg::WSW_CLOSED)
    else $error("no closed window");
  a_std_service: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r.st == wsw_pkg::WSW_OPEN && en && svc_evt && type_s) |=> r.st == wsw_pkg::WSW_OPEN && r.cnt == '0)
    else $error("open window not restarted");
  a_init_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r.st == wsw_pkg::WSW_INIT && en && !svc_evt && r.cnt == init_len - 1'b1) |=> watchdog_fault_oe)
    else $error("init timeout missed");
  a_open_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r.st == wsw_pkg::WSW_OPEN && en && !svc_evt && r.cnt == open_len - 1'b1) |=> watchdog_fault_oe)
    else $error("open timeout missed");
  a_quiet_out: assert property (@(posedge core_clk) disable iff (!rst_n)
    (r.st != wsw_pkg::WSW_FAULT) |-> !watchdog_fault_oe) else $error("fault out without fault");
endmodule : wsw_top

// ==== wsw_mcu.sv ====
`timescale 1ns/10ps
module wsw_mcu (
  output logic watchdog_service,
  input wire logic core_clk
);
  // ------------------------------------------------------------
  // service pulse source
  // ------------------------------------------------------------
  initial watchdog_service = 1'b0;

  // lead places the event; a short lead lands it in a closed window
  task automatic pulse(input int lead);
    repeat (lead) @(posedge core_clk);
    watchdog_service <= 1'b1;
    repeat (wsw_pkg::SVC_MIN_CYC + 100) @(posedge core_clk);
    watchdog_service <= 1'b0;
  endtask : pulse
endmodule : wsw_mcu

// ==== window_standard_watchdog_test.sv ====
`timescale 1ns/10ps
module window_standard_watchdog_test;
  localparam int P = 6000;
  localparam int H = P / 5;
  logic core_clk, nrst, power_good, watchdog_enable_n, watchdog_type_select, window_ratio_select;
  logic watchdog_service, watchdog_fault_out, watchdog_fault_oe, fault_pin;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_fail = 0;
  int samples_checked = 0;

  // open-drain pin with pull-up
  assign fault_pin = watchdog_fault_oe ? watchdog_fault_out : 1'b1;
  always #20 core_clk = ~core_clk;

  wsw_top #(.WD_PERIOD_CYC(P)) i_wsw_top (
    .core_clk(core_clk), .nrst(nrst), .power_good(power_good),
    .watchdog_enable_n(watchdog_enable_n), .watchdog_service(watchdog_service),
    .watchdog_type_select(watchdog_type_select), .window_ratio_select(window_ratio_select),
    .watchdog_fault_out(watchdog_fault_out), .watchdog_fault_oe(watchdog_fault_oe),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  wsw_mcu i_wsw_mcu (
    .watchdog_service(watchdog_service),
    .core_clk(core_clk)
  );

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, tr;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_bready & s_axi_bvalid;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_bready <= 1'b0;
    end while (!tr);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    logic ta, tr;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rready & s_axi_rvalid;
      v = s_axi_rdata;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end while (!tr);
  endtask : rd

  task automatic st(input wsw_pkg::wsw_state_t s);
    logic [31:0] v;
    rd(4'h4, v);
    chk(v & 32'h7, {29'h0, s});
  endtask : st

  // driver enable and pin level together
  task automatic oe(input logic e);
    @(negedge core_clk);
    chk({30'h0, watchdog_fault_oe, fault_pin}, {30'h0, e, ~e});
    @(posedge core_clk);
  endtask : oe

  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : waitc

  // window runs out len cycles after the last event, between the two oe checks
  task automatic expire(input int len, input int hold);
    waitc(len - 300);
    oe(1'b0);
    waitc(400);
    oe(1'b1);
    waitc(hold);
    oe(1'b0);
    st(wsw_pkg::WSW_INIT);
  endtask : expire

  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    power_good = 1'b0;
    watchdog_enable_n = 1'b1;
    watchdog_type_select = 1'b0;
    window_ratio_select = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    waitc(12);
    nrst <= 1'b1;
    waitc(5);
    rd(4'h0, d);
    chk(d, P);
    st(wsw_pkg::WSW_OFF);
    oe(1'b0);
    watchdog_enable_n <= 1'b0;
    waitc(20);
    st(wsw_pkg::WSW_OFF);
    oe(1'b0);
    wr(4'hc, 32'hffffffff);
    rd(4'hc, d);
    chk(d, 32'h0);
    power_good <= 1'b1;
    waitc(10);
    st(wsw_pkg::WSW_INIT);
    i_wsw_mcu.pulse(1);
    st(wsw_pkg::WSW_CLOSED);
    // rise only after the closed window has run out
    i_wsw_mcu.pulse(3000);
    st(wsw_pkg::WSW_CLOSED);
    oe(1'b0);
    i_wsw_mcu.pulse(100);
    oe(1'b1);
    st(wsw_pkg::WSW_FAULT);
    waitc(H - 300);
    oe(1'b1);
    waitc(400);
    oe(1'b0);
    st(wsw_pkg::WSW_INIT);
    rd(4'h8, d);
    chk(d, 32'h1);
    wr(4'h8, 32'h0);
    i_wsw_mcu.pulse(1);
    expire(P, H);
    window_ratio_select <= 1'b1;
    i_wsw_mcu.pulse(1);
    // rise after the short closed window, service in the long open one
    i_wsw_mcu.pulse(700);
    st(wsw_pkg::WSW_CLOSED);
    oe(1'b0);
    waitc(800);
    st(wsw_pkg::WSW_OPEN);
    watchdog_enable_n <= 1'b1;
    waitc(10);
    st(wsw_pkg::WSW_OFF);
    oe(1'b0);
    watchdog_type_select <= 1'b1;
    window_ratio_select <= 1'b0;
    watchdog_enable_n <= 1'b0;
    waitc(10);
    st(wsw_pkg::WSW_INIT);
    i_wsw_mcu.pulse(1);
    st(wsw_pkg::WSW_OPEN);
    i_wsw_mcu.pulse(100);
    st(wsw_pkg::WSW_OPEN);
    oe(1'b0);
    expire(P, H);
    power_good <= 1'b0;
    waitc(10);
    st(wsw_pkg::WSW_OFF);
    oe(1'b0);
    // low byte lane only
    s_axi_wstrb <= 4'h1;
    wr(4'h0, 32'hffffff00);
    rd(4'h0, d);
    chk(d, 32'h1700);
    s_axi_wstrb <= 4'hf;
    wr(4'h0, 32'd3000);
    rd(4'h0, d);
    chk(d, 32'd3000);
    power_good <= 1'b1;
    waitc(10);
    st(wsw_pkg::WSW_INIT);
    expire(8 * 3000, 600);
    rd(4'h8, d);
    chk(d, 32'h3);
    report_and_stop();
  end

  initial begin
    waitc(90000);
    n_fail++;
    report_and_stop();
  end
endmodule : window_standard_watchdog_test
